/* File: rtl/fxr_pkg.sv */
// Purpose: Shared constants, opcodes and frame layout for the extended read register link
// Assumes: Single-wire serial transfers; serial clock made by the host end
// Notes: Frame shape of every opcode is decided here so both ends agree
package fxr_pkg;
  // Opcodes
  localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] OP_RDSTAT = 8'h05;
  localparam logic [7:0] OP_WRSTAT = 8'h01;
  localparam logic [7:0] OP_RDEXT = 8'h81;
  localparam logic [7:0] OP_CLREXT = 8'h82;
  localparam logic [7:0] OP_SETEXT_V = 8'h83;
  localparam logic [7:0] OP_SETEXT_NV = 8'h85;
  localparam logic [7:0] OP_WRFUNC = 8'h42;
  localparam logic [7:0] OP_RDFUNC = 8'h48;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_PPQ = 8'h32;
  localparam logic [7:0] OP_IRP = 8'h62;
  localparam logic [7:0] OP_SER = 8'h20;
  localparam logic [7:0] OP_BER32 = 8'h52;
  localparam logic [7:0] OP_BER64 = 8'hD8;
  localparam logic [7:0] OP_CER = 8'hC7;
  localparam logic [7:0] OP_INFO_ROW_ERASE_CMD = 8'h64;
  localparam logic [7:0] OP_FRD = 8'h0B;
  localparam logic [7:0] OP_FRDTR = 8'h0D;
  localparam logic [7:0] OP_FRDO = 8'h3B;
  localparam logic [7:0] OP_FRQO = 8'h6B;
  localparam logic [7:0] OP_FRDIO = 8'hBB;
  localparam logic [7:0] OP_DUAL_IO_DOUBLE_EDGE_READ = 8'hBD;
  localparam logic [7:0] OP_FRQIO = 8'hEB;
  localparam logic [7:0] OP_FRQDTR = 8'hED;
  localparam logic [7:0] OP_UID = 8'h4B;
  localparam logic [7:0] OP_INFO_ROW_READ_CMD = 8'h68;
  localparam logic [7:0] OP_QPI_EN = 8'h35;
  localparam logic [7:0] OP_QPI_EX = 8'hF5;
  localparam logic [7:0] OP_SWRST = 8'h99;
  // Extended read register layout and reset value
  localparam int EXT_BUSY = 0;
  localparam int EXT_PROT = 1;
  localparam int EXT_PERR = 2;
  localparam int EXT_EERR = 3;
  localparam int EXT_RSVD = 4;
  localparam int EXT_DRV_LO = 5;
  localparam logic [7:0] EXT_RESET = 8'hF0;
  localparam logic [2:0] DRV_RESET = 3'h7;
  // Busy time of program, erase and non-volatile updates
  localparam int CLK_MHZ = 40;
  localparam int BUSY_TIME_NS = 2000;
  localparam int BUSY_CYC = (BUSY_TIME_NS * CLK_MHZ) / 1000;
  // Host side: serial clock half period and gap between frames
  localparam int HALF_CYC = 8;
  localparam int GAP_CYC = 16;
  // Host register offsets
  localparam logic [7:0] HR_CMD = 8'h00;
  localparam logic [7:0] HR_ADDR = 8'h04;
  localparam logic [7:0] HR_WDATA = 8'h08;
  localparam logic [7:0] HR_STAT = 8'h0C;

  typedef struct packed {
    logic addr;
    logic data;
    logic rd;
    logic [3:0] dummy;
  } fxr_frame_t;

  // Frame shape of an opcode; dummy count depends on instruction mode
  function automatic fxr_frame_t fxr_frame(input logic [7:0] op, input logic four_wire_instruction_mode);
    fxr_frame_t f;
    f = '{addr: 1'b0, data: 1'b0, rd: 1'b0, dummy: 4'h0};
    case (op)
      OP_RDSTAT, OP_RDEXT, OP_RDFUNC: f.rd = 1'b1;
      OP_WRSTAT, OP_SETEXT_V, OP_SETEXT_NV, OP_WRFUNC: f.data = 1'b1;
      OP_PP, OP_PPQ, OP_IRP: f = '{addr: 1'b1, data: 1'b1, rd: 1'b0, dummy: 4'h0};
      OP_SER, OP_BER32, OP_BER64, OP_INFO_ROW_ERASE_CMD: f.addr = 1'b1;
      OP_FRD, OP_FRDTR, OP_UID, OP_INFO_ROW_READ_CMD: f = '{addr: 1'b1, data: 1'b0, rd: 1'b1,
                                             dummy: (four_wire_instruction_mode ? 4'h6 : 4'h8)};
      OP_FRDO, OP_FRQO: f = '{addr: 1'b1, data: 1'b0, rd: 1'b1, dummy: 4'h8};
      OP_FRDIO, OP_DUAL_IO_DOUBLE_EDGE_READ: f = '{addr: 1'b1, data: 1'b0, rd: 1'b1, dummy: 4'h4};
      OP_FRQIO, OP_FRQDTR: f = '{addr: 1'b1, data: 1'b0, rd: 1'b1, dummy: 4'h6};
      default: f = '{addr: 1'b0, data: 1'b0, rd: 1'b0, dummy: 4'h0};
    endcase
    return f;
  endfunction

  // Commands that need the write enable latch
  function automatic logic fxr_needs_wel(input logic [7:0] op);
    case (op)
      OP_WRSTAT, OP_SETEXT_NV, OP_WRFUNC, OP_PP, OP_PPQ, OP_IRP,
      OP_SER, OP_BER32, OP_BER64, OP_CER, OP_INFO_ROW_ERASE_CMD: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
endpackage

/* File: rtl/fxr_link_if.sv */
// Purpose: Serial link between host end and flash end
// Assumes: Pull-up on both data wires when nobody drives
// Notes: Output enables are active low
`timescale 1ns/1ps
`default_nettype none
interface fxr_link_if;
  logic sck; // Serial clock from host
  logic cs_n; // Chip enable, active low
  logic h_io_o; // Host drive of data-in wire
  logic h_io_oe_n; // Host enable of data-in wire
  logic d_io_o; // Device drive of data-out wire
  logic d_io_oe_n; // Device enable of data-out wire
  logic io_in; // Resolved data-in wire level
  logic io_out; // Resolved data-out wire level
  // Wire resolution with pull-ups
  assign io_in = h_io_oe_n ? 1'b1 : h_io_o;
  assign io_out = d_io_oe_n ? 1'b1 : d_io_o;
  modport host (output sck, output cs_n, output h_io_o, output h_io_oe_n, input io_out);
  modport dev (input sck, input cs_n, input io_in, output d_io_o, output d_io_oe_n);
endinterface
`default_nettype wire

/* File: rtl/fxr_flash_end.sv */
// Purpose: Flash end: command decode, extended read register and error flags
// Assumes: Host keeps clock low between frames; one bit per clock on one wire
// Notes: Array behaviour is reduced to outcome inputs from the user side
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module fxr_flash_end (
  input wire logic SYS_CLK, // System clock
  input wire logic RST_N, // Synchronous reset, active low
  fxr_link_if.dev LINK, // Serial link
  input wire logic [7:0] READ_BYTE, // Array byte returned by reads
  input wire logic FAIL_PROG, // Next program phase fails
  input wire logic FAIL_ERASE, // Next erase phase fails
  input wire logic PROT_REGION, // Target lies in a protected region
  input wire logic ERASE_SUSP, // Target lies in a suspended region
  input wire logic INFO_LOCKED, // Target info row region is locked
  input wire logic WP_N, // Write protect pin, active low
  output logic [7:0] EXT_REG, // Extended read register
  output logic [9:0] DRIVE_PERMIL, // Drive strength in tenths of percent
  output logic [7:0] FUNC_REG, // Function register
  output logic QPI_MODE // Four-wire instruction mode flag
);
  typedef enum logic [5:0] {
    S_OPC = 6'h01, S_ADDR = 6'h02, S_DATA = 6'h04,
    S_DUMMY = 6'h08, S_OUT = 6'h10, S_DONE = 6'h20
  } fxr_dstate_t;

  logic [1:0] sck_sy, cs_sy, io_sy, wp_sy;
  logic sck_d, cs_d;
  logic rise, fall, cs_end;
  fxr_dstate_t state_reg;
  logic [4:0] cnt_reg;
  logic [7:0] op_reg, data_reg, sh_in, tx_reg;
  fxr_pkg::fxr_frame_t frm_reg, frm_now;
  logic [2:0] drv_reg, drv_nv_reg;
  logic [2:0] err_reg, err_set, err_clr;
  logic wel_reg, status_write_disable_bit_reg, qpi_reg;
  logic [3:0] bp_reg;
  logic [11:0] busy_reg;
  logic busy;
  logic exec, wel_ok, oe_reg;

  ////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for pins
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      sck_sy <= 2'h0;
      cs_sy <= 2'h3;
      io_sy <= 2'h3;
      wp_sy <= 2'h3;
    end else begin
      sck_sy <= {sck_sy[0], LINK.sck};
      cs_sy <= {cs_sy[0], LINK.cs_n};
      io_sy <= {io_sy[0], LINK.io_in};
      wp_sy <= {wp_sy[0], WP_N};
    end
  end

  // Edge detect on synchronised copies only
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      sck_d <= 1'b0;
      cs_d <= 1'b1;
    end else begin
      sck_d <= sck_sy[1];
      cs_d <= cs_sy[1];
    end
  end
  assign rise = sck_sy[1] & ~sck_d & ~cs_sy[1];
  assign fall = ~sck_sy[1] & sck_d & ~cs_sy[1];
  assign cs_end = cs_sy[1] & ~cs_d;
  assign sh_in = {data_reg[6:0], io_sy[1]};
  // double-edge dual read refused in four-wire mode
  assign frm_now = (qpi_reg && sh_in == fxr_pkg::OP_DUAL_IO_DOUBLE_EDGE_READ) ? '0 : fxr_pkg::fxr_frame(sh_in, qpi_reg);

  ////////////////////////////////////////////////////////////////////
  // Frame decoder; dummy counts come from the shared frame table
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N || cs_sy[1]) begin
      state_reg <= S_OPC;
      cnt_reg <= 5'h0;
      op_reg <= 8'h0;
      data_reg <= 8'h0;
      frm_reg <= '0;
    end else if (rise) begin
      data_reg <= sh_in;
      cnt_reg <= cnt_reg + 5'h1;
      case (state_reg)
        S_OPC: begin
          if (cnt_reg == 5'd7) begin
            op_reg <= sh_in;
            frm_reg <= frm_now;
            cnt_reg <= 5'h0;
            state_reg <= frm_now.addr ? S_ADDR : frm_now.data ? S_DATA :
                         frm_now.rd ? S_OUT : S_DONE;
          end
        end
        S_ADDR: begin
          if (cnt_reg == 5'd23) begin
            cnt_reg <= 5'h0;
            state_reg <= frm_reg.data ? S_DATA : !frm_reg.rd ? S_DONE :
                         (frm_reg.dummy != 4'h0) ? S_DUMMY : S_OUT;
          end
        end
        S_DATA: begin
          if (cnt_reg == 5'd7) begin
            cnt_reg <= 5'h0;
            state_reg <= S_DONE;
          end
        end
        S_DUMMY: begin
          if (cnt_reg == {1'b0, frm_reg.dummy} - 5'h1) begin
            cnt_reg <= 5'h0;
            state_reg <= S_OUT;
          end
        end
        S_OUT: begin
          if (cnt_reg == 5'd7) begin
            cnt_reg <= 5'h0;
          end
        end
        S_DONE: cnt_reg <= cnt_reg;
        default: state_reg <= S_OPC;
      endcase
    end
  end

  // Output shifter: load on the first fall of each byte, shift on later ones.
  // The out wire is enabled only from that first fall, after the host has let go.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N || cs_sy[1]) begin
      tx_reg <= 8'h0;
      oe_reg <= 1'b0;
    end else if (fall && state_reg == S_OUT) begin
      oe_reg <= 1'b1;
      if (cnt_reg == 5'h0) begin
        case (op_reg)
          fxr_pkg::OP_RDSTAT: tx_reg <= {status_write_disable_bit_reg, 1'b0, bp_reg, wel_reg, busy};
          fxr_pkg::OP_RDEXT: tx_reg <= EXT_REG;
          fxr_pkg::OP_RDFUNC: tx_reg <= FUNC_REG;
          default: tx_reg <= READ_BYTE;
        endcase
      end else begin
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
    end
  end
  assign LINK.d_io_o = tx_reg[7];
  assign LINK.d_io_oe_n = ~oe_reg;

  ////////////////////////////////////////////////////////////////////
  // Execution at chip enable release of a complete frame
  assign exec = cs_end && state_reg == S_DONE;
  assign wel_ok = wel_reg || !fxr_pkg::fxr_needs_wel(op_reg);

  // Error outcomes per command
  always_comb begin
    err_set = 3'h0; // {erase, program, protection}
    err_clr = 3'h0;
    if (exec && op_reg == fxr_pkg::OP_CLREXT) begin
      err_clr = 3'h7;
    end else if (exec && op_reg == fxr_pkg::OP_SWRST) begin
      err_clr = 3'h7;
    end else if (exec && wel_ok) begin
      case (op_reg)
        fxr_pkg::OP_PP, fxr_pkg::OP_PPQ: err_set = (PROT_REGION || ERASE_SUSP) ? 3'h3 :
                                                   {1'b0, FAIL_PROG, 1'b0};
        fxr_pkg::OP_IRP: err_set = INFO_LOCKED ? 3'h3 : {1'b0, FAIL_PROG, 1'b0};
        fxr_pkg::OP_WRSTAT: err_set = (status_write_disable_bit_reg && !wp_sy[1]) ? 3'h5 :
                                      {FAIL_ERASE, FAIL_PROG, 1'b0};
        fxr_pkg::OP_SETEXT_NV: err_set = {FAIL_ERASE, FAIL_PROG, 1'b0};
        fxr_pkg::OP_WRFUNC: err_set = {1'b0, FAIL_PROG, 1'b0};
        fxr_pkg::OP_SER, fxr_pkg::OP_BER32, fxr_pkg::OP_BER64: err_set = PROT_REGION ?
                                                  3'h5 : {FAIL_ERASE, 2'h0};
        fxr_pkg::OP_INFO_ROW_ERASE_CMD: err_set = INFO_LOCKED ? 3'h5 : {FAIL_ERASE, 2'h0};
        // chip erase with protect bits set
        fxr_pkg::OP_CER: err_set = (bp_reg != 4'h0) ? 3'h5 : {FAIL_ERASE, 2'h0};
        default: err_set = 3'h0;
      endcase
    end
  end

  // sticky flags, set wins over clear
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      err_reg <= 3'h0;
    end else begin
      err_reg <= (err_reg & ~err_clr) | err_set;
    end
  end

  // Write enable latch and four-wire mode; nothing checks the flags
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      wel_reg <= 1'b0;
      qpi_reg <= 1'b0;
    end else if (exec) begin
      if (op_reg == fxr_pkg::OP_WRITE_ENABLE_CMD) begin
        wel_reg <= 1'b1;
      end else if (fxr_pkg::fxr_needs_wel(op_reg)) begin
        wel_reg <= 1'b0;
      end
      if (op_reg == fxr_pkg::OP_QPI_EN) begin
        qpi_reg <= 1'b1;
      end else if (op_reg == fxr_pkg::OP_QPI_EX || op_reg == fxr_pkg::OP_SWRST) begin
        qpi_reg <= 1'b0;
      end
    end
  end

  // Busy timer for program, erase and non-volatile writes
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      busy_reg <= 12'h0;
    end else if (exec && wel_ok && fxr_pkg::fxr_needs_wel(op_reg)) begin
      busy_reg <= 12'(fxr_pkg::BUSY_CYC);
    end else if (busy_reg != 12'h0) begin
      busy_reg <= busy_reg - 12'h1;
    end
  end
  assign busy = (busy_reg != 12'h0);

  // Register writes; read-only bits in the data byte are dropped
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      drv_reg <= fxr_pkg::DRV_RESET;
      drv_nv_reg <= fxr_pkg::DRV_RESET;
      status_write_disable_bit_reg <= 1'b0;
      bp_reg <= 4'h0;
      FUNC_REG <= 8'h0;
    end else if (exec && op_reg == fxr_pkg::OP_SWRST) begin
      drv_reg <= drv_nv_reg;
    end else if (exec && wel_ok) begin
      case (op_reg)
        fxr_pkg::OP_SETEXT_V: drv_reg <= data_reg[7:5];
        fxr_pkg::OP_SETEXT_NV: begin
          drv_reg <= data_reg[7:5];
          drv_nv_reg <= data_reg[7:5];
        end
        fxr_pkg::OP_WRSTAT: begin
          if (!(status_write_disable_bit_reg && !wp_sy[1])) begin
            status_write_disable_bit_reg <= data_reg[7];
            bp_reg <= data_reg[5:2];
          end
        end
        fxr_pkg::OP_WRFUNC: FUNC_REG <= FUNC_REG | data_reg;
        default: drv_reg <= drv_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // status bits read-only, bit 4 reads one, bit 0 is busy
  assign EXT_REG = {drv_reg, 1'b1, err_reg[2], err_reg[1], err_reg[0], busy};
  assign QPI_MODE = qpi_reg;

  // strength decode, reserved codes give zero
  always_comb begin
    case (drv_reg)
      3'h1: DRIVE_PERMIL = 10'd125;
      3'h2: DRIVE_PERMIL = 10'd250;
      3'h3: DRIVE_PERMIL = 10'd375;
      3'h5: DRIVE_PERMIL = 10'd750;
      3'h6: DRIVE_PERMIL = 10'd1000;
      3'h7: DRIVE_PERMIL = 10'd500;
      default: DRIVE_PERMIL = 10'd0;
    endcase
  end
endmodule // fxr_flash_end
`default_nettype wire

/* File: rtl/fxr_host_end.sv */
// Purpose: Host end: APB command port driving the serial link
// Assumes: Serial clock idles low; device answers on the falling edge
// Notes: Write-class commands are preceded by a write enable frame
`timescale 1ns/1ps
`default_nettype none
module fxr_host_end (
  input wire logic SYS_CLK, // System clock
  input wire logic RST_N, // Synchronous reset, active low
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB access phase
  input wire logic PWRITE, // APB write
  input wire logic [7:0] PADDR, // APB byte address
  input wire logic [31:0] PWDATA, // APB write data
  output logic [31:0] PRDATA, // APB read data
  output logic PREADY, // APB ready
  output logic PSLVERR, // APB error on unmapped address
  fxr_link_if.host LINK // Serial link
);
  typedef enum logic [3:0] {
    H_IDLE = 4'h1, H_WRITE_ENABLE_CMD = 4'h2, H_CMD = 4'h4, H_GAP = 4'h8
  } fxr_hstate_t;

  fxr_hstate_t st_reg;
  logic [23:0] addr_reg;
  logic [7:0] wd_reg, op_reg, rx_reg;
  logic [39:0] sh_reg;
  logic [5:0] bit_reg, nbits, nout;
  logic [4:0] div_reg;
  logic sck_reg, cs_reg, refused_reg, qpi_reg, wr, start, frame_done;
  logic [1:0] rx_sy;
  fxr_pkg::fxr_frame_t frm;

  assign wr = PSEL && PENABLE && PWRITE;
  assign start = wr && PADDR == fxr_pkg::HR_CMD && st_reg == H_IDLE;
  assign frm = fxr_pkg::fxr_frame(st_reg == H_WRITE_ENABLE_CMD ? fxr_pkg::OP_WRITE_ENABLE_CMD : op_reg, qpi_reg);
  assign nout = 6'd8 + (frm.addr ? 6'd24 : 6'd0) + (frm.data ? 6'd8 : 6'd0);
  // dummy count from the shared table
  assign nbits = nout + {2'h0, frm.dummy} + (frm.rd ? 6'd8 : 6'd0);
  assign frame_done = !cs_reg && sck_reg && div_reg == 5'(fxr_pkg::HALF_CYC - 1)
                      && bit_reg == nbits - 6'h1;

  ////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      addr_reg <= 24'h0;
      wd_reg <= 8'h0;
    end else if (wr && PADDR == fxr_pkg::HR_ADDR) begin
      addr_reg <= PWDATA[23:0];
    end else if (wr && PADDR == fxr_pkg::HR_WDATA) begin
      wd_reg <= PWDATA[7:0];
    end
  end
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !(PADDR == fxr_pkg::HR_CMD || PADDR == fxr_pkg::HR_ADDR
                   || PADDR == fxr_pkg::HR_WDATA || PADDR == fxr_pkg::HR_STAT);
  always_comb begin
    case (PADDR)
      fxr_pkg::HR_ADDR: PRDATA = {8'h0, addr_reg};
      fxr_pkg::HR_WDATA: PRDATA = {24'h0, wd_reg};
      fxr_pkg::HR_STAT: PRDATA = {16'h0, rx_reg, 5'h0, qpi_reg, refused_reg, st_reg != H_IDLE};
      default: PRDATA = 32'h0;
    endcase
  end

  // Command sequencing; write enable first, refuse double-edge dual read in four-wire mode
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      st_reg <= H_IDLE;
      op_reg <= 8'h0;
      refused_reg <= 1'b0;
      qpi_reg <= 1'b0;
    end else begin
      case (st_reg)
        H_IDLE: begin
          if (start && qpi_reg && PWDATA[7:0] == fxr_pkg::OP_DUAL_IO_DOUBLE_EDGE_READ) begin
            refused_reg <= 1'b1;
          end else if (start) begin
            refused_reg <= 1'b0;
            op_reg <= PWDATA[7:0];
            st_reg <= fxr_pkg::fxr_needs_wel(PWDATA[7:0]) ? H_WRITE_ENABLE_CMD : H_CMD;
          end
        end
        H_WRITE_ENABLE_CMD: if (frame_done) st_reg <= H_CMD;
        H_CMD: begin
          if (frame_done) begin
            st_reg <= H_GAP;
            if (op_reg == fxr_pkg::OP_QPI_EN) qpi_reg <= 1'b1;
            if (op_reg == fxr_pkg::OP_QPI_EX || op_reg == fxr_pkg::OP_SWRST) qpi_reg <= 1'b0;
          end
        end
        H_GAP: if (cs_reg && div_reg == 5'(fxr_pkg::GAP_CYC - 1)) st_reg <= H_IDLE;
        default: st_reg <= H_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Serial engine; chip enable high between frames for a gap
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N || st_reg == H_IDLE || frame_done) begin
      cs_reg <= 1'b1;
      sck_reg <= 1'b0;
      div_reg <= 5'h0;
      bit_reg <= 6'h0;
      sh_reg <= 40'h0;
    end else if (cs_reg) begin
      div_reg <= div_reg + 5'h1;
      if (st_reg != H_GAP && div_reg == 5'(fxr_pkg::GAP_CYC - 1)) begin
        cs_reg <= 1'b0;
        div_reg <= 5'h0;
        sh_reg <= frm.addr ? {(st_reg == H_WRITE_ENABLE_CMD ? fxr_pkg::OP_WRITE_ENABLE_CMD : op_reg), addr_reg, wd_reg}
                           : {(st_reg == H_WRITE_ENABLE_CMD ? fxr_pkg::OP_WRITE_ENABLE_CMD : op_reg), wd_reg, 24'h0};
      end
    end else if (div_reg == 5'(fxr_pkg::HALF_CYC - 1)) begin
      div_reg <= 5'h0;
      sck_reg <= ~sck_reg;
      if (sck_reg) begin
        bit_reg <= bit_reg + 6'h1;
        sh_reg <= {sh_reg[38:0], 1'b0};
      end
    end else begin
      div_reg <= div_reg + 5'h1;
    end
  end

  // Read sampling on rising edges after the dummies
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      rx_sy <= 2'h3;
      rx_reg <= 8'h0;
    end else begin
      rx_sy <= {rx_sy[0], LINK.io_out};
      if (!cs_reg && !sck_reg && div_reg == 5'(fxr_pkg::HALF_CYC - 1) && frm.rd
          && bit_reg >= nbits - 6'd8 && st_reg == H_CMD) begin
        rx_reg <= {rx_reg[6:0], rx_sy[1]};
      end
    end
  end

  assign LINK.sck = sck_reg;
  assign LINK.cs_n = cs_reg;
  assign LINK.h_io_o = sh_reg[39];
  // float the data wire during dummies and reads
  assign LINK.h_io_oe_n = cs_reg || bit_reg >= nout;
endmodule // fxr_host_end
`default_nettype wire

/* File: verification/fxr_link_props.sv */
// Purpose: Link framing and register checks
// Assumes: Watches the link and the flash end outputs
// Notes: Flags only move outside frames
`timescale 1ns/1ps
`default_nettype none
module fxr_link_props (
  input wire logic SYS_CLK, // Clock
  input wire logic RST_N, // Reset
  input wire logic sck, // Serial clock
  input wire logic cs_n, // Chip enable
  input wire logic h_io_oe_n, // Host enable
  input wire logic d_io_oe_n, // Device enable
  input wire logic [7:0] EXT_REG, // Ext register
  input wire logic [9:0] DRIVE_PERMIL // Strength
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////
  // Strength per code, zero on reserved codes
  logic [9:0] tbl [8];
  assign tbl = '{10'h000, 10'h07D, 10'h0FA, 10'h177, 10'h000, 10'h2EE, 10'h3E8, 10'h1F4};
  property p_drv; DRIVE_PERMIL == tbl[EXT_REG[7:5]]; endproperty
  a_drv: assert property (p_drv) else $error("drive decode wrong");
  property p_rsvd; EXT_REG[4]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit low");
  // Within a frame nothing has executed yet, so flags hold
  property p_stick; !cs_n && $past(!cs_n) |-> $stable(EXT_REG[3:1]); endproperty
  a_stick: assert property (p_stick) else $error("flag moved in frame");
  property p_busy; $rose(EXT_REG[0]) |-> ##[1:100] !EXT_REG[0]; endproperty
  a_busy: assert property (p_busy) else $error("busy too long");
  // Device sees chip enable through two flops, so it lets go a few cycles late
  property p_dev; cs_n [*4] |-> d_io_oe_n; endproperty
  a_dev: assert property (p_dev) else $error("device drives idle");
  property p_cont; !d_io_oe_n |-> h_io_oe_n; endproperty
  a_cont: assert property (p_cont) else $error("wire contention");
  property p_half; $rose(sck) |-> sck [*8] ##1 !sck; endproperty
  a_half: assert property (p_half) else $error("sck high time");
  property p_lead; $fell(cs_n) |-> !sck [*8]; endproperty
  a_lead: assert property (p_lead) else $error("sck too early");
  c_out: cover property (!d_io_oe_n);
  c_busy: cover property ($rose(EXT_REG[0]));
  c_clr: cover property ($fell(EXT_REG[2]));
endmodule // fxr_link_props
`default_nettype wire

/* File: verification/flash_ext_read_status_reg_bench.sv */
// Purpose: Both ends joined, driven over APB
// Assumes: Host end sends write enable itself
// Notes: Array outcomes come from bench inputs
`timescale 1ns/1ps
`default_nettype none
module flash_ext_read_status_reg_bench;
  logic clk, rst_n, psel, pen, pwr, pready, pslverr, err, fp, fe, pr, wp_n, es, il;
  logic [7:0] paddr, rb, ext;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0] drv;
  logic [9:0] tbl [8] = '{10'h000, 10'h07D, 10'h0FA, 10'h177, 10'h000, 10'h2EE, 10'h3E8, 10'h1F4};
  logic [7:0] rop [10] = '{8'h0B, 8'h0D, 8'h3B, 8'h6B, 8'hBB, 8'hBD, 8'hEB, 8'hED, 8'h4B, 8'h68};
  // Dummy clocks per read opcode above, as the rules give them
  int dmy [10] = '{8, 8, 8, 8, 4, 4, 6, 6, 8, 8};
  int n_fail, num_checks, cyc, nsck;
  fxr_link_if lk ();
  fxr_host_end fxr_host_end_inst (.SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .LINK(lk));
  fxr_flash_end fxr_flash_end_inst (.SYS_CLK(clk), .RST_N(rst_n), .LINK(lk), .READ_BYTE(rb),
    .FAIL_PROG(fp), .FAIL_ERASE(fe), .PROT_REGION(pr), .ERASE_SUSP(es), .INFO_LOCKED(il),
    .WP_N(wp_n), .EXT_REG(ext), .DRIVE_PERMIL(drv), .FUNC_REG(), .QPI_MODE());
  fxr_link_props fxr_link_props_inst (.SYS_CLK(clk), .RST_N(rst_n), .sck(lk.sck),
    .cs_n(lk.cs_n), .h_io_oe_n(lk.h_io_oe_n), .d_io_oe_n(lk.d_io_oe_n), .EXT_REG(ext),
    .DRIVE_PERMIL(drv));
  // count serial clock rises of the latest frame
  always @(negedge lk.cs_n) nsck = 0;
  always @(posedge lk.sck) nsck++;
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  // One APB transfer; data taken at the edge where pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask
  // Issue an opcode, then poll until host and device are both idle
  task automatic run(input logic [7:0] op, input logic [7:0] wd);
    apb(1'h1, fxr_pkg::HR_WDATA, {24'h0, wd});
    apb(1'h1, fxr_pkg::HR_CMD, {24'h0, op});
    do apb(1'h0, fxr_pkg::HR_STAT, 32'h0); while (rd[0] !== 1'h0 || ext[0] !== 1'h0);
  endtask
  task automatic wrap_up;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_drive;
    for (int c = 0; c < 8; c++) begin
      run(fxr_pkg::OP_SETEXT_V, {c[2:0], 5'h0F});
      chk("ext drive", {2'h0, c[2:0], 5'h10}, {2'h0, ext});
      chk("permil", tbl[c], drv);
    end
  endtask
  task automatic t_errors;
    fp <= 1'h1;
    run(fxr_pkg::OP_PP, 8'h00);
    fp <= 1'h0;
    chk("prog err", 10'h0F4, {2'h0, ext});
    pr <= 1'h1;
    run(fxr_pkg::OP_SER, 8'h00);
    pr <= 1'h0;
    chk("erase err", 10'h0FE, {2'h0, ext});
  endtask
  // Wrong dummy counts would shift the returned byte
  task automatic t_reads;
    foreach (rop[i]) begin
      rb <= 8'h5A ^ rop[i];
      run(rop[i], 8'h00);
      chk("read byte", {2'h0, rb}, {2'h0, rd[15:8]});
      chk("sck rises", 10'(40 + dmy[i]), 10'(nsck));
    end
    chk("flags kept", 10'h0FE, {2'h0, ext});
    run(fxr_pkg::OP_CLREXT, 8'h00);
    chk("cleared", 10'h0F0, {2'h0, ext});
  endtask
  task automatic t_qpi;
    run(fxr_pkg::OP_QPI_EN, 8'h00);
    chk("four-wire", 10'h001, {9'h0, rd[2]});
    rb <= 8'hC3;
    run(fxr_pkg::OP_FRD, 8'h00);
    chk("qpi read", 10'h0C3, {2'h0, rd[15:8]});
    chk("qpi sck rises", 10'd46, 10'(nsck));
    run(fxr_pkg::OP_DUAL_IO_DOUBLE_EDGE_READ, 8'h00);
    chk("refused", 10'h001, {9'h0, rd[1]});
    run(fxr_pkg::OP_QPI_EX, 8'h00);
  endtask
  // Locked info row, suspended region and failed non-volatile update
  task automatic t_lock;
    {es, il} <= 2'h3;
    run(fxr_pkg::OP_IRP, 8'h00);
    chk("info lock", 10'h0F6, {2'h0, ext});
    run(fxr_pkg::OP_CLREXT, 8'h00);
    run(fxr_pkg::OP_PP, 8'h00);
    {es, il} <= 2'h0;
    chk("susp prog", 10'h0F6, {2'h0, ext});
    run(fxr_pkg::OP_CLREXT, 8'h00);
    fe <= 1'h1;
    run(fxr_pkg::OP_SETEXT_NV, 8'hE0);
    fe <= 1'h0;
    chk("nv update", 10'h0F8, {2'h0, ext});
    run(fxr_pkg::OP_CLREXT, 8'h00);
  endtask
  task automatic t_wp;
    run(fxr_pkg::OP_WRSTAT, 8'h80);
    wp_n <= 1'h0;
    run(fxr_pkg::OP_WRSTAT, 8'h80);
    chk("wp block", 10'h0FA, {2'h0, ext});
    run(fxr_pkg::OP_SWRST, 8'h00);
    chk("soft reset", 10'h0F0, {2'h0, ext});
    apb(1'h0, 8'h40, 32'h0);
    chk("slverr", 10'h001, {9'h0, err});
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  // Hang guard: generous against about 18k expected cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_fail++;
      wrap_up();
    end
  end
  initial begin
    {rst_n, psel, pen, pwr, fp, fe, pr, es, il} = 9'h000;
    wp_n = 1'h1;
    paddr = 8'h00;
    pwdata = 32'h0;
    rb = 8'h00;
    repeat (20) @(posedge clk);
    chk("reset ext", 10'h0F0, {2'h0, ext});
    chk("reset drv", 10'h1F4, drv);
    rst_n <= 1'h1;
    run(fxr_pkg::OP_RDEXT, 8'h00);
    chk("ext read", 10'h0F0, {2'h0, rd[15:8]});
    t_drive();
    t_errors();
    t_reads();
    t_qpi();
    t_lock();
    t_wp();
    wrap_up();
  end
endmodule // flash_ext_read_status_reg_bench
`default_nettype wire
